// ---- pkg/irr_pkg.sv ----
/*
  Package for the infrared remote carrier modem: register offsets, field
  positions, reset values, divider codes and state encodings.
  Assumes a plain register port with 16-bit data and word indices.
*/
package irr_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] IRR_CFG_ADDR = 2'h0;
  localparam logic [1:0] IRR_CAR_ADDR = 2'h1;
  localparam logic [1:0] IRR_LEN_ADDR = 2'h2;
  localparam logic [1:0] IRR_INT_ADDR = 2'h3;
  // Configuration register fields
  localparam int IRR_CG_DIV_LSB = 12;
  localparam int IRR_LC_DIV_LSB = 8;
  localparam int IRR_MODE_BIT = 1;
  localparam int IRR_EN_BIT = 0;
  // Carrier register fields
  localparam int IRR_CH_LSB = 8;
  localparam int IRR_CL_LSB = 0;
  // Length counter register fields
  localparam int IRR_LEVEL_BIT = 8;
  localparam int IRR_LEN_LSB = 0;
  // Interrupt register: enables in [10:8], flags in [2:0]
  localparam int IRR_IE_LSB = 8;
  localparam int IRR_UF_BIT = 0;
  localparam int IRR_RF_BIT = 1;
  localparam int IRR_FF_BIT = 2;
  // Divider codes and widths
  localparam logic [3:0] IRR_DIV_RSVD = 4'hF;
  localparam int IRR_PRE_W = 14;
  localparam logic [13:0] IRR_PRE_ONE = 14'h0001;
  localparam logic [7:0] IRR_LEN_ZERO = 8'h00;
  localparam logic [5:0] IRR_PH_ZERO = 6'h00;
  localparam logic [15:0] IRR_WORD_ZERO = 16'h0000;
  // Noise filter: level must stand for this many samples
  localparam logic [1:0] IRR_FILT_CNT = 2'h2;
  // Carrier phase states
  typedef enum logic [1:0] {
    IRR_PH_HIGH = 2'b01,
    IRR_PH_LOW  = 2'b10
  } irr_phase_e;
endpackage

// ---- core/irr_div_tick.sv ----
/*
  Power-of-two tick generator: one-cycle pulse every 2**code clocks.
  Assumes code stays constant while enabled; reserved code gives no ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module irr_div_tick
  import irr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [3:0] code,
  // Tick out
  output logic tick
);
  logic [IRR_PRE_W-1:0] cnt_r;
  logic [IRR_PRE_W-1:0] cnt_nxt;
  logic tick_nxt;
  logic [IRR_PRE_W-1:0] span;

  // Count up and tick when the selected span is reached
  always_comb
  begin
    span = (IRR_PRE_ONE << code) - IRR_PRE_ONE; // see [RL1] see [RL3]
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!run || code == IRR_DIV_RSVD)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r >= span)
    begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
    else
    begin
      cnt_nxt = cnt_r + IRR_PRE_ONE;
    end
  end

  // Register counter and tick
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule // irr_div_tick
`default_nettype wire

// ---- core/irr_edge_filt.sv ----
/*
  Receive input synchroniser and edge detector with a two-sample noise filter.
  Assumes samp is a one-cycle strobe from the carrier divider.
*/
`timescale 1ns/1ps
`default_nettype none
module irr_edge_filt
  import irr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic samp,
  // Pin
  input wire logic ir_receive_input,
  // Edge pulses
  output logic rise,
  output logic fall
);
  logic sync1_r;
  logic sync2_r;
  logic level_r;
  logic level_nxt;
  logic [1:0] same_r;
  logic [1:0] same_nxt;
  logic rise_nxt;
  logic fall_nxt;

  // Accept a new level once it stands for two samples
  always_comb
  begin
    level_nxt = level_r;
    same_nxt = same_r;
    rise_nxt = 1'b0;
    fall_nxt = 1'b0;
    if (!run)
    begin
      level_nxt = sync2_r;
      same_nxt = '0;
    end
    else if (samp)
    begin
      if (sync2_r == level_r)
      begin
        same_nxt = '0; // Glitch back: treat as noise, see [RL17]
      end
      else if (same_r + 2'h1 >= IRR_FILT_CNT)
      begin
        level_nxt = sync2_r;
        same_nxt = '0;
        rise_nxt = sync2_r; // see [RL15]
        fall_nxt = !sync2_r; // see [RL15]
      end
      else
      begin
        same_nxt = same_r + 2'h1;
      end
    end
  end

  // Synchroniser and filter state
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      level_r <= 1'b0;
      same_r <= '0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      sync1_r <= ir_receive_input;
      sync2_r <= sync1_r;
      level_r <= level_nxt;
      same_r <= same_nxt;
      rise <= rise_nxt;
      fall <= fall_nxt;
    end
  end
endmodule // irr_edge_filt
`default_nettype wire

// ---- core/irr_remote_unit.sv ----
/*
  Infrared remote carrier modem: registers, carrier generator, modulator,
  data length counter, edge causes and shared interrupt request.
  Assumes a plain register port on mclk and an IR receive pin from outside.
*/
// Summary of operation
// [RL1] Carrier clock is mclk over two to the divider code; code F reserved.
// [RL2] Carrier high lasts high field plus one, low lasts low field plus one.
// [RL3] Length clock has its own divider code with the same ratios.
// [RL4] Writing the length field loads the counter; it decrements per tick.
// [RL5] At zero the counter raises underflow, stops and holds zero.
// [RL6] Underflow requests an interrupt only when its enable is set.
// [RL7] Mode bit zero is transmit, one is receive.
// [RL8] Enable starts the selected mode; clearing it halts the block.
// [RL9] Transmit output is the level bit gated by the carrier.
// [RL10] Software clears level and length before enabling transmit.
// [RL11] Software changes clock and interrupt settings only while disabled.
// [RL12] Software computes length as duration times length clock rate.
// [RL13] Software writes next level then length in the underflow handler.
// [RL14] Software disables only after the final underflow.
// [RL15] Receive samples the input on the carrier clock and flags edges.
// [RL16] Rising and falling causes have separate enables.
// [RL17] A level held under two samples is noise and flags nothing.
// [RL18] Software measures pulses by loading FF and reading at next edge.
// [RL19] Software picks a length clock so pulses fit 256 counts.
// [RL20] Three causes share one interrupt; flags clear by writing one.
// [RL21] The length counter also runs and underflows in receive mode.
// [RL22] Reset clears all fields and the transmit output idles low.
// [RL23] Carrier restarts at its high phase whenever the block is enabled.
`timescale 1ns/1ps
`default_nettype none
module irr_remote_unit
  import irr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Infrared pins
  input wire logic ir_receive_input,
  output logic ir_transmit_output,
  // Interrupt request
  output logic irq
);
  // Register state
  logic [3:0] carrier_clock_divider_r, carrier_clock_divider_nxt;
  logic [3:0] length_clock_divider_r, length_clock_divider_nxt;
  logic direction_mode_r, direction_mode_nxt;
  logic unit_enable_r, unit_enable_nxt;
  logic [5:0] carrier_high_length_r, carrier_high_length_nxt;
  logic [5:0] carrier_low_length_r, carrier_low_length_nxt;
  logic transmit_level_r, transmit_level_nxt;
  logic [7:0] pulse_length_value_r, pulse_length_value_nxt;
  logic [2:0] int_en_r, int_en_nxt;
  logic [2:0] int_flag_r, int_flag_nxt;
  logic [15:0] reg_rdata_nxt;
  logic irq_nxt;
  // Carrier state
  irr_phase_e phase_r, phase_nxt;
  logic [5:0] ph_cnt_r, ph_cnt_nxt;
  logic out_nxt;
  // Ticks and edges
  logic cg_tick;
  logic lc_tick;
  logic rise;
  logic fall;
  logic underflow;
  logic wr_len;

  // Write to a given register index
  function automatic logic wr_hit(input logic [1:0] idx);
    wr_hit = reg_wr && (reg_addr == idx);
  endfunction

  // Carrier clock divider
  irr_div_tick u_cg_div (
    .mclk(mclk),
    .reset(reset),
    .run(unit_enable_r),
    .code(carrier_clock_divider_r),
    .tick(cg_tick)
  );

  // Length counter clock divider, independent code
  irr_div_tick u_lc_div (
    .mclk(mclk),
    .reset(reset),
    .run(unit_enable_r),
    .code(length_clock_divider_r),
    .tick(lc_tick)
  );

  // Receive edge detector, only in receive mode
  irr_edge_filt u_edge (
    .mclk(mclk),
    .reset(reset),
    .run(unit_enable_r && direction_mode_r), // see [RL7] see [RL8]
    .samp(cg_tick),
    .ir_receive_input(ir_receive_input),
    .rise(rise),
    .fall(fall)
  );

  assign wr_len = wr_hit(IRR_LEN_ADDR);
  // Counter reaching zero from one on a tick, in either mode
  assign underflow = unit_enable_r && lc_tick && !wr_len
    && (pulse_length_value_r == 8'h01); // see [RL5] see [RL21]

  // Register file next values
  always_comb
  begin
    carrier_clock_divider_nxt = carrier_clock_divider_r;
    length_clock_divider_nxt = length_clock_divider_r;
    direction_mode_nxt = direction_mode_r;
    unit_enable_nxt = unit_enable_r;
    carrier_high_length_nxt = carrier_high_length_r;
    carrier_low_length_nxt = carrier_low_length_r;
    transmit_level_nxt = transmit_level_r;
    pulse_length_value_nxt = pulse_length_value_r;
    int_en_nxt = int_en_r;
    int_flag_nxt = int_flag_r;
    if (wr_hit(IRR_CFG_ADDR))
    begin
      carrier_clock_divider_nxt = reg_wdata[IRR_CG_DIV_LSB +: 4];
      length_clock_divider_nxt = reg_wdata[IRR_LC_DIV_LSB +: 4];
      direction_mode_nxt = reg_wdata[IRR_MODE_BIT]; // see [RL7]
      unit_enable_nxt = reg_wdata[IRR_EN_BIT]; // see [RL8]
    end
    if (wr_hit(IRR_CAR_ADDR))
    begin
      carrier_high_length_nxt = reg_wdata[IRR_CH_LSB +: 6];
      carrier_low_length_nxt = reg_wdata[IRR_CL_LSB +: 6];
    end
    // Load on write, else count down and stop at zero
    if (wr_len)
    begin
      transmit_level_nxt = reg_wdata[IRR_LEVEL_BIT];
      pulse_length_value_nxt = reg_wdata[IRR_LEN_LSB +: 8]; // see [RL4]
    end
    else if (unit_enable_r && lc_tick && pulse_length_value_r != IRR_LEN_ZERO)
    begin
      pulse_length_value_nxt = pulse_length_value_r - 8'h01; // see [RL4] see [RL5]
    end
    if (wr_hit(IRR_INT_ADDR))
    begin
      int_en_nxt = reg_wdata[IRR_IE_LSB +: 3]; // see [RL16]
      int_flag_nxt = int_flag_r & ~reg_wdata[2:0]; // see [RL20]
    end
    // Set wins over a clear in the same cycle
    int_flag_nxt[IRR_UF_BIT] = int_flag_nxt[IRR_UF_BIT] | underflow; // see [RL5]
    int_flag_nxt[IRR_RF_BIT] = int_flag_nxt[IRR_RF_BIT] | rise; // see [RL15]
    int_flag_nxt[IRR_FF_BIT] = int_flag_nxt[IRR_FF_BIT] | fall; // see [RL15]
    irq_nxt = |(int_flag_nxt & int_en_nxt); // see [RL6] see [RL16] see [RL20]
    // Read data
    reg_rdata_nxt = IRR_WORD_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        IRR_CFG_ADDR: reg_rdata_nxt = {carrier_clock_divider_r, length_clock_divider_r,
          6'h00, direction_mode_r, unit_enable_r};
        IRR_CAR_ADDR: reg_rdata_nxt = {2'h0, carrier_high_length_r, 2'h0,
          carrier_low_length_r};
        IRR_LEN_ADDR: reg_rdata_nxt = {7'h00, transmit_level_r, pulse_length_value_r};
        IRR_INT_ADDR: reg_rdata_nxt = {5'h00, int_en_r, 5'h00, int_flag_r};
        default: reg_rdata_nxt = IRR_WORD_ZERO;
      endcase
    end
  end

  // Carrier generator and modulator next values
  always_comb
  begin
    phase_nxt = phase_r;
    ph_cnt_nxt = ph_cnt_r;
    if (!unit_enable_r)
    begin
      phase_nxt = IRR_PH_HIGH; // see [RL23]
      ph_cnt_nxt = IRR_PH_ZERO;
    end
    else if (cg_tick)
    begin
      case (phase_r)
        IRR_PH_HIGH:
        begin
          if (ph_cnt_r >= carrier_high_length_r) // see [RL2]
          begin
            phase_nxt = IRR_PH_LOW;
            ph_cnt_nxt = IRR_PH_ZERO;
          end
          else
          begin
            ph_cnt_nxt = ph_cnt_r + 6'h01;
          end
        end
        IRR_PH_LOW:
        begin
          if (ph_cnt_r >= carrier_low_length_r) // see [RL2]
          begin
            phase_nxt = IRR_PH_HIGH;
            ph_cnt_nxt = IRR_PH_ZERO;
          end
          else
          begin
            ph_cnt_nxt = ph_cnt_r + 6'h01;
          end
        end
        default:
        begin
          phase_nxt = IRR_PH_HIGH;
          ph_cnt_nxt = IRR_PH_ZERO;
        end
      endcase
    end
    // Level gated by carrier, transmit mode only
    out_nxt = unit_enable_r && !direction_mode_r && transmit_level_r
      && (phase_nxt == IRR_PH_HIGH); // see [RL9]
  end

  // Register all state
  always_ff @(posedge mclk)
  begin
    if (reset) // see [RL22]
    begin
      carrier_clock_divider_r <= 4'h0;
      length_clock_divider_r <= 4'h0;
      direction_mode_r <= 1'b0;
      unit_enable_r <= 1'b0;
      carrier_high_length_r <= IRR_PH_ZERO;
      carrier_low_length_r <= IRR_PH_ZERO;
      transmit_level_r <= 1'b0;
      pulse_length_value_r <= IRR_LEN_ZERO;
      int_en_r <= 3'h0;
      int_flag_r <= 3'h0;
      reg_rdata <= IRR_WORD_ZERO;
      irq <= 1'b0;
      phase_r <= IRR_PH_HIGH;
      ph_cnt_r <= IRR_PH_ZERO;
      ir_transmit_output <= 1'b0;
    end
    else
    begin
      carrier_clock_divider_r <= carrier_clock_divider_nxt;
      length_clock_divider_r <= length_clock_divider_nxt;
      direction_mode_r <= direction_mode_nxt;
      unit_enable_r <= unit_enable_nxt;
      carrier_high_length_r <= carrier_high_length_nxt;
      carrier_low_length_r <= carrier_low_length_nxt;
      transmit_level_r <= transmit_level_nxt;
      pulse_length_value_r <= pulse_length_value_nxt;
      int_en_r <= int_en_nxt;
      int_flag_r <= int_flag_nxt;
      reg_rdata <= reg_rdata_nxt;
      irq <= irq_nxt;
      phase_r <= phase_nxt;
      ph_cnt_r <= ph_cnt_nxt;
      ir_transmit_output <= out_nxt;
    end
  end

  // Underflow sequence: counter at one, a tick, then zero and flag
  sequence last_tick_s;
    unit_enable_r && lc_tick && !wr_len && pulse_length_value_r == 8'h01;
  endsequence
  sequence zero_flag_s;
    pulse_length_value_r == 8'h00 && int_flag_r[IRR_UF_BIT];
  endsequence

  uf_sets_flag_a: assert property (@(posedge mclk) disable iff (reset) // see [RL5]
    last_tick_s |=> zero_flag_s) else $error("underflow did not flag at zero");
  zero_hold_a: assert property (@(posedge mclk) disable iff (reset) // see [RL5]
    (pulse_length_value_r == 8'h00 && !wr_len) |=> pulse_length_value_r == 8'h00)
    else $error("length counter left zero without a write");
  len_load_a: assert property (@(posedge mclk) disable iff (reset) // see [RL4]
    wr_len |=> pulse_length_value_r == $past(reg_wdata[7:0]))
    else $error("length write did not load counter");
  len_step_a: assert property (@(posedge mclk) disable iff (reset) // see [RL4]
    (!wr_len && !lc_tick) |=> $stable(pulse_length_value_r))
    else $error("length counter moved without a tick");
  irq_gate_a: assert property (@(posedge mclk) disable iff (reset) // see [RL6]
    irq == |(int_flag_r & int_en_r))
    else $error("interrupt disagrees with enabled flags");
  tx_idle_a: assert property (@(posedge mclk) disable iff (reset) // see [RL9]
    (!transmit_level_r || direction_mode_r) |=> !ir_transmit_output)
    else $error("transmit output high without level");
  rx_quiet_a: assert property (@(posedge mclk) disable iff (reset) // see [RL15]
    (rise || fall) |-> $past(unit_enable_r && direction_mode_r, 2))
    else $error("edge flagged outside receive mode");
  restart_high_a: assert property (@(posedge mclk) disable iff (reset) // see [RL23]
    !unit_enable_r |=> phase_r == IRR_PH_HIGH && ph_cnt_r == 6'h00)
    else $error("carrier did not restart high");
  flag_sticky_a: assert property (@(posedge mclk) disable iff (reset) // see [RL20]
    (int_flag_r[IRR_UF_BIT] && !wr_hit(IRR_INT_ADDR)) |=> int_flag_r[IRR_UF_BIT])
    else $error("underflow flag dropped without a clear");
endmodule // irr_remote_unit
`default_nettype wire

// ---- test/irr_ir_model.sv ----
/*
  Infrared far side of the modem: a receiver front end that drives the
  receive pin, and an emitter that counts the cycles its diode is lit.
  Assumes the bench sets the steady level and asks for short inverted pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module irr_ir_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Receive waveform control
  input wire logic rx_level,
  input wire logic [3:0] pulse_cycles,
  input wire logic pulse_go,
  // Pins
  input wire logic ir_transmit_output,
  output logic ir_receive_input,
  // Emitter activity
  output logic [15:0] emit_cnt
);
  logic [3:0] left_r;

  // Inverted pulse on top of the steady level, for noise and short marks
  always_ff @(posedge mclk)
  begin
    if (reset)
      left_r <= 4'h0;
    else if (pulse_go)
      left_r <= pulse_cycles;
    else if (left_r != 4'h0)
      left_r <= left_r - 4'h1;
  end

  assign ir_receive_input = rx_level ^ (left_r != 4'h0);

  // Diode on time, counted per clock
  always_ff @(posedge mclk)
  begin
    if (reset)
      emit_cnt <= 16'h0000;
    else if (ir_transmit_output === 1'b1)
      emit_cnt <= emit_cnt + 16'h0001;
  end
endmodule // irr_ir_model
`default_nettype wire

// ---- test/testbench.sv ----
/*
  Self-checking bench for the infrared remote carrier modem.
  Assumes the package, the modem and the pin model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import irr_pkg::*;
;
  logic mclk, reset, reg_wr, reg_rd, irq, rd_q;
  logic ir_receive_input, ir_transmit_output, rx_level, pulse_go;
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, emit_cnt;
  logic [3:0] pulse_cycles;
  logic [15:0] exp_q[$];
  int mismatches, tests_run;

  // Free running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  irr_remote_unit dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ir_receive_input(ir_receive_input), .ir_transmit_output(ir_transmit_output),
    .irq(irq));

  irr_ir_model ir_u (.mclk(mclk), .reset(reset), .rx_level(rx_level),
    .pulse_cycles(pulse_cycles), .pulse_go(pulse_go),
    .ir_transmit_output(ir_transmit_output), .ir_receive_input(ir_receive_input),
    .emit_cnt(emit_cnt));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    mismatches++;
    end_of_test();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One write cycle, then a quiet cycle
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // One read cycle; the watcher compares the data in the next cycle
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  // Cycles for which the output keeps one level, bounded
  task automatic run_len(input logic lvl, output int n);
    for (n = 0; n < 40000 && ir_transmit_output === lvl; n++)
      @(posedge mclk);
    if (n == 40000)
      give_up();
  endtask

  // Skip the partial first low, one high and one low, then time one high and one low
  task automatic measure(input logic [15:0] hi, input logic [15:0] lo);
    int n;
    run_len(1'b0, n);
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk(n[15:0], hi);
    run_len(1'b0, n);
    chk(n[15:0], lo);
  endtask

  task automatic wait_irq(output int n);
    for (n = 0; n < 200 && irq !== 1'b1; n++)
      @(posedge mclk);
    if (n == 200)
      give_up();
  endtask

  // Enable with the length cleared, then set the level and count the lit cycles
  task automatic tx_quiet(input logic [15:0] cfg, input logic [15:0] len,
    input logic [15:0] lit);
    logic [15:0] base;
    wr(IRR_CFG_ADDR, cfg);
    wr(IRR_LEN_ADDR, 16'h0000);
    wr(IRR_CFG_ADDR, cfg | 16'h0001);
    wr(IRR_LEN_ADDR, len);
    base = emit_cnt;
    idle(50);
    chk(emit_cnt - base, lit);
    wr(IRR_CFG_ADDR, 16'h0000);
  endtask

  // Read data watcher: the oldest note is the value due this cycle
  always @(posedge mclk)
  begin
    rd_q <= reg_rd;
    if (rd_q === 1'b1)
      chk(reg_rdata, exp_q.pop_front());
  end

  // Main sequence
  initial
  begin
    int n;
    logic [3:0] codes [4];
    logic [15:0] h, l;
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    rx_level = 1'b0;
    pulse_go = 1'b0;
    pulse_cycles = 4'h0;
    codes = '{4'h0, 4'h1, 4'h3, 4'hE};
    void'($urandom(32'h6701));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 4; a++)
      rd(a[1:0], 16'h0000);
    chk({15'h0000, ir_transmit_output}, 16'h0000);
    // Field widths and reserved bits
    wr(IRR_CFG_ADDR, 16'hFFFE);
    rd(IRR_CFG_ADDR, 16'hFF02);
    wr(IRR_CAR_ADDR, 16'hFFFF);
    rd(IRR_CAR_ADDR, 16'h3F3F);
    wr(IRR_INT_ADDR, 16'h0700);
    rd(IRR_INT_ADDR, 16'h0700);
    wr(IRR_CFG_ADDR, 16'h0000);
    wr(IRR_CAR_ADDR, 16'h0000);
    wr(IRR_INT_ADDR, 16'h0000);
    // Carrier phases over several divider codes; length cleared before enable
    for (int i = 0; i < 4; i++)
    begin
      h = (i == 3) ? 16'h0000 : 16'($urandom % 4);
      l = (i == 3) ? 16'h0000 : 16'($urandom % 4);
      wr(IRR_CFG_ADDR, 16'(codes[i]) << IRR_CG_DIV_LSB);
      wr(IRR_CAR_ADDR, (h << IRR_CH_LSB) | l);
      wr(IRR_LEN_ADDR, 16'h0000);
      wr(IRR_CFG_ADDR, (16'(codes[i]) << IRR_CG_DIV_LSB) | 16'h0001);
      wr(IRR_LEN_ADDR, 16'h0101);
      measure((h + 16'h1) << codes[i], (l + 16'h1) << codes[i]);
      wr(IRR_CFG_ADDR, 16'h0000);
      idle(2);
      chk({15'h0000, ir_transmit_output}, 16'h0000);
    end
    // Reserved carrier code gives no ticks: the diode stands lit with the level; code 0 with level zero stays dark
    tx_quiet(16'hF000, 16'h0101, 16'h0031);
    tx_quiet(16'h0000, 16'h0001, 16'h0000);
    // Length counter, underflow and its interrupt; stale flags cleared first
    wr(IRR_CFG_ADDR, 16'h0200);
    wr(IRR_INT_ADDR, 16'h0107);
    wr(IRR_LEN_ADDR, 16'h0000);
    wr(IRR_CFG_ADDR, 16'h0201);
    wr(IRR_LEN_ADDR, 16'h0105);
    wait_irq(n);
    chk({15'h0000, (n >= 15) && (n <= 22)}, 16'h0001);
    rd(IRR_LEN_ADDR, 16'h0100);
    idle(20);
    rd(IRR_LEN_ADDR, 16'h0100);
    rd(IRR_INT_ADDR, 16'h0101);
    wr(IRR_INT_ADDR, 16'h0101);
    idle(2);
    chk({15'h0000, irq}, 16'h0000);
    rd(IRR_INT_ADDR, 16'h0100);
    wr(IRR_LEN_ADDR, 16'h0002);
    wait_irq(n);
    chk({15'h0000, (n >= 4) && (n <= 10)}, 16'h0001);
    wr(IRR_CFG_ADDR, 16'h0000);
    // Receive: noise, rising edge, falling edge with its cause masked
    wr(IRR_CFG_ADDR, 16'h1002);
    wr(IRR_INT_ADDR, 16'h0207);
    wr(IRR_LEN_ADDR, 16'h0003);
    wr(IRR_CFG_ADDR, 16'h1003);
    idle(10);
    pulse_cycles <= 4'h2;
    pulse_go <= 1'b1;
    @(posedge mclk);
    pulse_go <= 1'b0;
    idle(20);
    rd(IRR_INT_ADDR, 16'h0201);
    chk({15'h0000, irq}, 16'h0000);
    rx_level <= 1'b1;
    idle(20);
    rd(IRR_INT_ADDR, 16'h0203);
    chk({15'h0000, irq}, 16'h0001);
    wr(IRR_INT_ADDR, 16'h0202);
    // Length loaded full after the rising edge, counting one per cycle
    wr(IRR_LEN_ADDR, 16'h00FF);
    rx_level <= 1'b0;
    idle(20);
    rd(IRR_LEN_ADDR, 16'h00EA);
    rd(IRR_INT_ADDR, 16'h0205);
    chk({15'h0000, irq}, 16'h0000);
    wr(IRR_CFG_ADDR, 16'h0000);
    idle(2);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
